// [src/wdt_pkg.sv]
/*
  Shared constants for the watchdog timer unit: control register address,
  field layout, reset value, counter sizing and timebase rates.
  Assumes a single 200 MHz core clock and an 8-bit special function register bus.
*/
// Contract
// - no timeout action at all while the enable bit is clear.
// - software refreshes the enable bit before timeout, else reset or interrupt follows.
// - the 16-bit timeout counter advances on the 32.768 kHz timebase, not the core clock.
// - prescale 0..7 selects 512 << prescale periods; 8 resets at once; above is reserved.
// - on timeout, select bit set gives an interrupt, clear gives a system reset.
// - timeout sets the status flag, which survives the watchdog reset.
// - enable clears when software writes zero, or on a watchdog reset in reset mode.
// - control writes not preceded by the unlock step are ignored.
// - after power-on the control register holds 10H.
package wdt_pkg;

  // register address and power-on value
  localparam logic [7:0] ADDR_CTRL = 8'hC0;
  localparam logic [7:0] CTRL_RST  = 8'h10;

  // field positions inside the control register
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_FLAG   = 2;
  localparam int BIT_IRQSEL = 3;
  localparam int PRE_LSB    = 4;
  localparam int PRE_W      = 4;

  // prescale codes
  localparam logic [3:0] PRE_MAX_TIMED = 4'h7;
  localparam logic [3:0] PRE_IMMEDIATE = 4'h8;

  // counter sizing: base period is 2^9 timebase ticks
  localparam int          CNT_W      = 16;
  localparam logic [16:0] BASE_TICKS = 17'h0_0200;

  // rates: core clock and low-frequency timebase
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int TB_FREQ_HZ  = 32_768;

  // unlock sequencer states
  typedef enum logic [0:0] {
    UNLK_IDLE  = 1'b0,
    UNLK_ARMED = 1'b1
  } wdt_unlock_e;

endpackage : wdt_pkg

// [src/wdt_tick_div.sv]
/*
  Fractional divider that turns the core clock into one-cycle timebase
  enable pulses at TICK_HZ on average.
  Assumes TICK_HZ < CLK_HZ < 2^31; clr_i restarts the phase from zero.
*/
`timescale 1ns/1ps
module wdt_tick_div #(
  parameter int CLK_HZ  = wdt_pkg::CLK_FREQ_HZ,
  parameter int TICK_HZ = wdt_pkg::TB_FREQ_HZ
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // control
  input  wire logic clr_i,
  // timebase enable
  output logic      tick_o
);

  localparam logic [31:0] INC = 32'(TICK_HZ);
  localparam logic [31:0] MOD = 32'(CLK_HZ);

  logic [31:0] acc_reg;
  logic [31:0] acc_sum;
  logic        wrap;

  // phase accumulator keeps the long-term rate exact despite 6103.5 cycles per tick
  assign acc_sum = acc_reg + INC;
  assign wrap    = acc_sum >= MOD;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_reg <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else if (clr_i) begin
      acc_reg <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else begin
      acc_reg <= wrap ? acc_sum - MOD : acc_sum;
      tick_o  <= wrap;
    end
  end

endmodule : wdt_tick_div

// [src/wdt_unit.sv]
/*
  Watchdog timer unit: control register on the core's special function
  register bus, protected write sequence, 16-bit timeout counter on a
  derived 32.768 kHz timebase, reset or interrupt on expiry.
  Assumes bus strobes are one-cycle pulses synchronous to clk_i, and that
  warm_rst_i reflects every system reset (including our own) except power-on.
  Limitation: reserved prescale codes freeze the counter at zero, so an
  enabled watchdog then never fires; software must keep away from them.
  Bit-addressable writes pass through the same unlock guard as byte writes.
*/
`timescale 1ns/1ps
module wdt_unit #(
  parameter int CLK_HZ  = wdt_pkg::CLK_FREQ_HZ,
  parameter int TICK_HZ = wdt_pkg::TB_FREQ_HZ
) (
  // clock and power-on reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // system warm reset, keeps the timeout flag
  input  wire logic       warm_rst_i,
  // special function register bus, byte access
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  // special function register bus, single-bit access
  input  wire logic       sfr_bit_wr_i,
  input  wire logic [2:0] sfr_bit_sel_i,
  input  wire logic       sfr_bit_val_i,
  // read data
  output logic [7:0]      sfr_rdata_o,
  // watchdog actions and status
  output logic            wd_sys_reset_o,
  output logic            wd_irq_o,
  output logic            wd_enabled_o,
  output logic            wd_timeout_flag_o
);

  // control register fields
  logic [3:0]          wd_prescale_field_reg;
  logic                wd_irq_not_reset_select_reg;
  logic                wd_timeout_flag_reg;
  logic                wd_enable_refresh_reg;
  wdt_pkg::wdt_unlock_e unlock_reg;
  logic [wdt_pkg::CNT_W-1:0] count_reg;

  // decode wires
  logic       hit;
  logic       byte_wr;
  logic       bit_wr;
  logic       any_wr;
  logic       other_wr;
  logic [7:0] ctrl_image;
  logic [7:0] bit_mask;
  logic [7:0] bit_image;
  logic [7:0] wr_image;
  logic       accept;
  logic       arm;

  // timeout wires
  logic        tick;
  logic        timed_mode;
  logic        immediate;
  logic [16:0] span;
  logic [15:0] count_last;
  logic        expire;
  logic        do_reset;
  logic        do_irq;
  logic        cnt_clear;
  logic        refresh;

  // readback image; the unlock bit reads back as armed state
  assign ctrl_image = {wd_prescale_field_reg, wd_irq_not_reset_select_reg,
                       wd_timeout_flag_reg, wd_enable_refresh_reg, unlock_reg == wdt_pkg::UNLK_ARMED};

  // address decode and write image; single-bit writes merge into the current value
  assign hit       = sfr_addr_i == wdt_pkg::ADDR_CTRL;
  assign byte_wr   = sfr_wr_i & hit;
  assign bit_wr    = sfr_bit_wr_i & hit;
  assign any_wr    = byte_wr | bit_wr;
  assign other_wr  = (sfr_wr_i | sfr_bit_wr_i) & ~hit;
  assign bit_mask  = 8'h01 << sfr_bit_sel_i;
  assign bit_image = sfr_bit_val_i ? (ctrl_image | bit_mask) : (ctrl_image & ~bit_mask);
  assign wr_image  = byte_wr ? sfr_wdata_i : bit_image;

  // protected write: an idle write that sets the unlock bit only arms
  assign arm    = any_wr & (unlock_reg == wdt_pkg::UNLK_IDLE) & wr_image[wdt_pkg::BIT_UNLOCK];
  assign accept = any_wr & (unlock_reg == wdt_pkg::UNLK_ARMED);

  // refresh: accepted write with enable set restarts the period
  assign refresh = accept & wr_image[wdt_pkg::BIT_ENABLE];

  // timeout selection: 512 << prescale timebase periods, last count is span-1
  assign timed_mode = wd_prescale_field_reg <= wdt_pkg::PRE_MAX_TIMED;
  assign immediate  = wd_prescale_field_reg == wdt_pkg::PRE_IMMEDIATE;
  assign span       = wdt_pkg::BASE_TICKS << wd_prescale_field_reg[2:0];
  assign count_last = span[15:0] - 16'h0001; // prescale 7 gives span 10000H, so span[15:0] is 0, last = FFFF

  // an accepted write in the same cycle takes precedence over expiry, the
  // trade being that a refresh racing the last tick still rescues the system
  assign expire   = wd_enable_refresh_reg & ~accept & ~warm_rst_i &
                    ((timed_mode & tick & (count_reg == count_last)) | immediate);
  assign do_reset = expire & (immediate | ~wd_irq_not_reset_select_reg);
  assign do_irq   = expire & ~immediate & wd_irq_not_reset_select_reg;

  // counter and timebase restart whenever the watchdog is off, refreshed or expired
  assign cnt_clear = ~wd_enable_refresh_reg | refresh | expire | warm_rst_i;

  // timebase enable pulses, never the core clock directly
  wdt_tick_div #(
    .CLK_HZ  (CLK_HZ),
    .TICK_HZ (TICK_HZ)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (cnt_clear),
    .tick_o  (tick)
  );

  // 16-bit timeout counter, advanced only by the timebase enable
  // the divider restarts with the counter, so a refresh always buys a full period
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= 16'h0000;
    end else if (cnt_clear) begin
      count_reg <= 16'h0000;
    end else if (tick & timed_mode) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // unlock sequencer: any write after arming consumes the unlock, even to another
  // register, so the protected write must be the very next bus write
  // keeping interrupts out of the pair is the core's job; we only see bus writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unlock_reg <= wdt_pkg::UNLK_IDLE;
    end else begin
      case (unlock_reg)
        wdt_pkg::UNLK_IDLE: begin
          if (arm & ~warm_rst_i) begin
            unlock_reg <= wdt_pkg::UNLK_ARMED;
          end
        end
        wdt_pkg::UNLK_ARMED: begin
          if (accept | other_wr | warm_rst_i) begin
            unlock_reg <= wdt_pkg::UNLK_IDLE;
          end
        end
        default: begin
          unlock_reg <= wdt_pkg::UNLK_IDLE;
        end
      endcase
    end
  end

  // prescale and select fields: loaded only by an accepted write
  // warm reset returns both fields to their power-on values
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_prescale_field_reg       <= wdt_pkg::CTRL_RST[wdt_pkg::PRE_LSB +: wdt_pkg::PRE_W];
      wd_irq_not_reset_select_reg <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_IRQSEL];
    end else if (warm_rst_i) begin
      wd_prescale_field_reg       <= wdt_pkg::CTRL_RST[wdt_pkg::PRE_LSB +: wdt_pkg::PRE_W];
      wd_irq_not_reset_select_reg <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_IRQSEL];
    end else if (accept) begin
      wd_prescale_field_reg       <= wr_image[wdt_pkg::PRE_LSB +: wdt_pkg::PRE_W];
      wd_irq_not_reset_select_reg <= wr_image[wdt_pkg::BIT_IRQSEL];
    end
  end

  // enable bit: software write, warm reset, or own reset-mode expiry clears it
  // the expiry clear lands a cycle before the warm reset it provokes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_enable_refresh_reg <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_ENABLE];
    end else if (warm_rst_i | do_reset) begin
      wd_enable_refresh_reg <= 1'b0;
    end else if (accept) begin
      wd_enable_refresh_reg <= wr_image[wdt_pkg::BIT_ENABLE];
    end
  end

  // timeout flag: only power-on clears it by reset; an accepted write in the same cycle suppresses a new timeout
  // software may still clear it through an accepted write after reading it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_timeout_flag_reg <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_FLAG];
    end else if (expire) begin
      wd_timeout_flag_reg <= 1'b1;
    end else if (accept & ~warm_rst_i) begin
      wd_timeout_flag_reg <= wr_image[wdt_pkg::BIT_FLAG];
    end
  end

  // action outputs: one-cycle pulses from flip-flops
  // registered so the core's reset logic never sees a decode glitch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_sys_reset_o <= 1'b0;
      wd_irq_o       <= 1'b0;
    end else begin
      wd_sys_reset_o <= do_reset;
      wd_irq_o       <= do_irq;
    end
  end

  // read data: registered, zero for any other address or when not reading
  // zero when idle lets the core merge read data from many units with an or
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i & hit) begin
      sfr_rdata_o <= ctrl_image;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // status taps come straight from the field registers
  assign wd_enabled_o      = wd_enable_refresh_reg;
  assign wd_timeout_flag_o = wd_timeout_flag_reg;

endmodule : wdt_unit

// [dv/wdt_unit_monitor.sv]
/* wdt_unit_monitor: port-level checks on wdt_unit.
   Assumes bind to wdt_unit; one clock domain. */
`timescale 1ns/1ps
module wdt_unit_monitor (
  // clock and resets
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       warm_rst_i,
  // write side of the bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic       sfr_bit_val_i,
  // watchdog outputs
  input wire logic       wd_sys_reset_o,
  input wire logic       wd_irq_o,
  input wire logic       wd_enabled_o,
  input wire logic       wd_timeout_flag_o
);
  logic armed_reg;
  logic guarded;
  logic any_wr;
  logic arm_bit;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // shadow of the unlock state; a bit write arms only when it sets bit 0
  assign any_wr  = sfr_wr_i || sfr_bit_wr_i;
  assign arm_bit = sfr_wr_i ? sfr_wdata_i[0] : (sfr_bit_sel_i == 3'h0 && sfr_bit_val_i);
  assign guarded = any_wr && armed_reg && sfr_addr_i == wdt_pkg::ADDR_CTRL && !warm_rst_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) armed_reg <= 1'b0;
    else if (warm_rst_i) armed_reg <= 1'b0;
    else if (any_wr) armed_reg <= !armed_reg && sfr_addr_i == wdt_pkg::ADDR_CTRL && arm_bit;
  end
  a_rst_one_cycle: assert property (wd_sys_reset_o |=> !wd_sys_reset_o) else $error("long reset");
  a_act_needs_en: assert property (wd_sys_reset_o || wd_irq_o |-> $past(wd_enabled_o)) else $error("act off");
  a_irq_keeps_en: assert property (wd_irq_o |-> wd_enabled_o && wd_timeout_flag_o) else $error("irq");
  a_rst_clears_en: assert property (wd_sys_reset_o |-> !wd_enabled_o && wd_timeout_flag_o) else $error("rst");
  a_flag_survives: assert property (warm_rst_i |=> $stable(wd_timeout_flag_o)) else $error("flag lost");
  a_warm_disables: assert property (warm_rst_i |=> !wd_enabled_o) else $error("warm enable");
  a_raw_write_dropped: assert property (any_wr && !armed_reg && !warm_rst_i
    |=> wd_enabled_o == $past(wd_enabled_o) || wd_sys_reset_o) else $error("raw write");
  a_en_needs_unlock: assert property ($rose(wd_enabled_o) |-> $past(guarded)) else $error("en rise");
  c_reset: cover property (wd_sys_reset_o);
  c_irq: cover property (wd_irq_o);
  c_warm_flag: cover property (warm_rst_i && wd_timeout_flag_o);
endmodule : wdt_unit_monitor

bind wdt_unit wdt_unit_monitor i_wdt_unit_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i), .warm_rst_i(warm_rst_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i),
  .sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i), .wd_sys_reset_o(wd_sys_reset_o),
  .wd_irq_o(wd_irq_o), .wd_enabled_o(wd_enabled_o), .wd_timeout_flag_o(wd_timeout_flag_o));

// [dv/wdt_core_model.sv]
/* wdt_core_model: processor side of the register bus plus system reset logic.
   Assumes one-cycle strobes and read data one cycle after the read strobe. */
`timescale 1ns/1ps
module wdt_core_model (
  // clock, reset and unit outputs
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       wd_sys_reset_i,
  input  wire logic [7:0] rdata_i,
  // towards the unit
  output logic            warm_rst_o,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o,
  output logic            rd_o,
  output logic            bit_wr_o,
  output logic [2:0]      bit_sel_o,
  output logic            bit_val_o
);
  initial begin
    {addr_o, wr_o, wdata_o, rd_o, bit_wr_o, bit_sel_o, bit_val_o} = '0;
  end
  // a watchdog request becomes a one-cycle warm reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) warm_rst_o <= 1'b0;
    else warm_rst_o <= wd_sys_reset_i;
  end
  // write held until its edge, unlock byte first when guarded; idle cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic arm);
    addr_o = a;
    wr_o = 1'b1;
    if (arm) begin
      wdata_o = 8'h01;
      @(posedge clk_i);
      #1;
    end
    wdata_o = d;
    @(posedge clk_i);
    #1 wr_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask : wr
  // single-bit write held to its edge; arming and the target bit are separate calls
  task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    addr_o = a;
    bit_sel_o = s;
    bit_val_o = v;
    bit_wr_o = 1'b1;
    @(posedge clk_i);
    #1 bit_wr_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask : bwr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1 rd_o = 1'b0;
    d = rdata_i;
    @(posedge clk_i);
    #1;
  endtask : rd
endmodule : wdt_core_model

// [dv/wdt_unit_tb.sv]
/* wdt_unit_tb: self-checking bench with a register model.
   Assumes wdt_core_model drives the bus and warm reset. */
`timescale 1ns/1ps
module wdt_unit_tb;
  localparam int CPT = 4; // clocks per tick with the fast timebase
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        warm, wr, rd, rst_o, irq_o, en_o, flag_o;
  logic [7:0]  addr, wdata, rdata;
  logic        bit_wr, bit_val;
  logic [2:0]  bit_sel;
  logic [31:0] n;
  int          bad_count = 0;
  int          checks = 0;
  int          exp_reg = 8'h10;
  always #2.5 clk_i = ~clk_i;
  wdt_core_model i_wdt_core_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .wd_sys_reset_i(rst_o), .rdata_i(rdata),
    .warm_rst_o(warm), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
    .bit_wr_o(bit_wr), .bit_sel_o(bit_sel), .bit_val_o(bit_val));
  // bit writes share the byte path's address and unlock guard
  wdt_unit #(.TICK_HZ(50_000_000)) i_wdt_unit (.clk_i(clk_i), .rst_b_i(rst_b_i), .warm_rst_i(warm),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_bit_wr_i(bit_wr),
    .sfr_bit_sel_i(bit_sel), .sfr_bit_val_i(bit_val), .sfr_rdata_o(rdata), .wd_sys_reset_o(rst_o),
    .wd_irq_o(irq_o), .wd_enabled_o(en_o), .wd_timeout_flag_o(flag_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_wdt_core_model.rd(a, d);
    chk("read data", d, e);
  endtask : rdc
  task automatic pw(input logic [7:0] d);
    i_wdt_core_model.wr(8'hC0, d, 1'b1);
    exp_reg = d & 8'hFE;
  endtask : pw
  // bounded wait for a pulse; a full count means none came
  task automatic wait_ev(input int lim);
    n = 0;
    while (rst_o !== 1'b1 && irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask : wait_ev
  task automatic expect_ev(input int p);
    int t;
    t = (512 << p) * CPT;
    wait_ev(t + 20);
    if (n >= t + 20) begin
      bad_count++;
      print_verdict();
    end else begin
      chk("expiry time", n + 6 >= t && n <= t + 6, 1'b1);
    end
  endtask : expect_ev
  initial begin
    n = $urandom(69);
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    rdc(8'hC0, exp_reg[7:0]);
    rdc(8'hC1, 8'h00);
    i_wdt_core_model.wr(8'hC0, ($urandom & 8'hFE) | 8'h02, 1'b0);
    rdc(8'hC0, exp_reg[7:0]);
    i_wdt_core_model.wr(8'hC0, 8'h01, 1'b0);
    i_wdt_core_model.wr(8'hA0, 8'h00, 1'b0);
    i_wdt_core_model.wr(8'hC0, 8'h02, 1'b0);
    rdc(8'hC0, exp_reg[7:0]);
    i_wdt_core_model.bwr(8'hC0, 3'h1, 1'b1);
    rdc(8'hC0, exp_reg[7:0]);
    i_wdt_core_model.bwr(8'hC0, 3'h0, 1'b1);
    i_wdt_core_model.bwr(8'hC0, 3'h1, 1'b1);
    exp_reg = 8'h12;
    rdc(8'hC0, exp_reg[7:0]);
    $display("guard test done");
    pw(8'h02);
    rdc(8'hC0, exp_reg[7:0]);
    repeat ($urandom_range(1800, 200)) @(posedge clk_i);
    #1 pw(8'h02);
    expect_ev(0);
    chk("reset", {rst_o, en_o, flag_o}, 3'h5);
    repeat (3) @(posedge clk_i);
    #1 exp_reg = 8'h14;
    rdc(8'hC0, exp_reg[7:0]);
    $display("reset test done");
    pw(8'h1A);
    expect_ev(1);
    chk("irq", {rst_o, irq_o, en_o, flag_o}, 4'h7);
    pw(8'h10);
    wait_ev(5000);
    chk("idle", n, 5000);
    rdc(8'hC0, exp_reg[7:0]);
    $display("irq test done");
    pw(8'h92);
    wait_ev(3000);
    chk("reserved", n, 3000);
    pw(8'h82);
    wait_ev(10);
    chk("immediate", rst_o, 1'b1);
    $display("prescale test done");
    print_verdict();
  end
endmodule : wdt_unit_tb
